//--- design/clk_startup_pkg.sv
// Package for the clock source start-up block: register map, codes and timing.
// Assumes a single 250 MHz system clock; watchdog and source clocks arrive as tick inputs.
package clk_startup_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the AXI4-Lite bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h00;
	localparam logic [7:0] ADDR_MCU_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_OSC_CAL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_WAKE = 8'h10;

	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	localparam int CSEL_LSB = 0;
	localparam int CSUT_LSB = 4;
	localparam int RANGE_BIT = 0;
	localparam int ST_RC_EN = 0;
	localparam int ST_RUN = 1;
	localparam int ST_RANGE = 2;
	localparam int ST_DIV8 = 3;
	localparam int ST_RST_DIS = 4;
	localparam int ST_STATE_LSB = 8;

	// ----------------------------------------------------------------
	// Clock source and start-up codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CSEL_EXT_CLK = 4'h0;
	localparam logic [3:0] CSEL_PLL_RC = 4'h1;
	localparam logic [3:0] CSEL_RC_8M = 4'h2;
	localparam logic [3:0] CSEL_WD_128K = 4'h3;
	localparam logic [3:0] CSEL_PLL_XOSC = 4'h4;
	localparam logic [3:0] CSEL_PLL_XCLK = 4'h5;
	localparam logic [3:0] CSEL_RC_1M = 4'h6;
	localparam logic [3:0] CSEL_XOSC_C = 4'hc;
	localparam logic [3:0] CSEL_XOSC_D = 4'hd;
	localparam logic [1:0] SUT_SHORT = 2'h0;
	localparam logic [1:0] SUT_FAST = 2'h1;
	localparam logic [1:0] SUT_SLOW = 2'h2;
	localparam logic [1:0] SUT_RSVD = 2'h3;

	// Unprogrammed fuse defaults
	localparam logic [3:0] CSEL_DEFAULT = CSEL_RC_8M;
	localparam logic [1:0] SUT_DEFAULT = SUT_SLOW;
	localparam logic DIV8_DEFAULT = 1'b1;

	// ----------------------------------------------------------------
	// Timing, in cycles of the source or watchdog oscillator
	// ----------------------------------------------------------------
	localparam logic [13:0] CK_POWERDOWN = 14'd6;
	localparam logic [13:0] CK_RESET = 14'd14;
	localparam logic [13:0] WD_4MS = 14'd512;
	localparam logic [13:0] WD_64MS = 14'd8192;
	localparam logic [13:0] ZERO_CNT = 14'h0;
	localparam logic [13:0] ONE_CNT = 14'h1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] csel;
		logic [1:0] csut;
		logic div8;
		logic rst_dis;
		logic [7:0] cal;
	} fuse_t;

	typedef struct packed {
		logic rc_en;
		logic range_1m;
		logic [7:0] trim;
	} rc_ctrl_t;

	// Gray order along reset -> source delay -> watchdog delay -> run
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SRC = 3'b001,
		S_WDOG = 3'b011,
		S_RUN = 3'b010,
		S_WAKE = 3'b110
	} start_state_t;

endpackage

//--- design/tick_counter.sv
// Counts tick pulses up to a target and flags when the target is reached.
// Assumes ticks are single-cycle pulses in the system clock domain.
`timescale 1ns/1ns
module tick_counter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic tick,
	input wire logic [13:0] target,
	output logic done
);
	logic [13:0] count_reg;
	logic [13:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (clear) begin
			count_next = clk_startup_pkg::ZERO_CNT;
		end else if (tick && count_reg < target) begin
			count_next = count_reg + clk_startup_pkg::ONE_CNT;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= clk_startup_pkg::ZERO_CNT;
		end else begin
			count_reg <= count_next;
		end
	end

	assign done = !clear && (count_reg >= target);
endmodule

//--- design/clock_gate_glitchless.sv
// Glitch-free gate for the released system clock enable.
// Assumes the enable request is synchronous; the enable is registered on the rising clock edge, with no latch.
`timescale 1ns/1ns
module clock_gate_glitchless (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en_req,
	output logic en_out
);
	logic en_reg;
	logic en_next;

	// A registered enable only changes right after an edge, so the gated clock never chops a pulse
	always_comb begin
		en_next = en_req;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
		end
	end

	assign en_out = en_reg;
endmodule

//--- design/clock_source_startup_select.sv
// Clock source selection and start-up timing for the internal RC and 128 kHz sources.
// Assumes fuse values are stable inputs and oscillator ticks are synchronous pulses.
//
// Contract
// - Every reset copies clock select and startup fuses into clock select register.
// - Power-on start-up uses source and delay held in clock select register.
// - Unprogrammed defaults: select 0010, startup 10, divide-by-eight programmed.
// - At reset range select is 1 for code 0110, else 0.
// - RC oscillator off for codes 0011, 0100, 0101, 1100, 1101.
// - RC oscillator stays on when it is system clock or PLL reference.
// - RC output is 8 MHz or 1 MHz per range select bit.
// - Reset loads factory calibration byte into oscillator calibration register.
// - Software writes to calibration register change the trim at once.
// - Watchdog oscillator times reset delay even when RC clocks the chip.
// - RC start-up 6CK; reset adds 14CK, 14CK+4.1ms, 14CK+65ms; 11 reserved.
// - Reset pin disabled with startup 00 on RC lengthens delay to 14CK+4.1ms.
// - 128 kHz start-up 6CK; reset 14CK, 14CK+4ms, 14CK+64ms; 11 reserved.
// - Code 0011 is 128 kHz watchdog clock, 0110 is RC at 1 MHz.
// - Real-time delay: 512 watchdog cycles for 4 ms, 8192 for 64 ms.
// - Wake or clock switch counts source start-up cycles before execution resumes.
`timescale 1ns/1ns
module clock_source_startup_select (
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic [3:0] I_FUSE_CLOCK_SELECT,
	input wire logic [1:0] I_FUSE_STARTUP_TIME,
	input wire logic I_FUSE_DIVIDE_BY_EIGHT,
	input wire logic I_FUSE_RESET_PIN_DISABLE,
	input wire logic [7:0] I_FACTORY_CAL,
	input wire logic I_SRC_TICK,
	input wire logic I_WDOG_TICK,
	input wire logic I_WAKE,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic O_RC_ENABLE,
	output logic O_RC_RANGE_1M,
	output logic [7:0] O_RC_TRIM,
	output logic O_WDOG_CLK_SELECT,
	output logic O_SYS_CLK_EN,
	output logic O_DIVIDE_BY_EIGHT
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Configuration state
	// ----------------------------------------------------------------
	logic [3:0] csel_reg, csel_next;
	logic [1:0] csut_reg, csut_next;
	logic range_reg, range_next;
	logic [7:0] cal_reg, cal_next;
	logic div8_reg, div8_next;
	logic rst_dis_reg, rst_dis_next;
	logic loaded_reg, loaded_next;
	logic wake_req_reg, wake_req_next;
	clk_startup_pkg::start_state_t state_reg, state_next;

	// Bus slave state
	logic aw_full_reg, aw_full_next;
	logic w_full_reg, w_full_next;
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic aw_bad_reg, aw_bad_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	logic do_write;
	logic [31:0] status_word;
	logic src_done, wdog_done;
	logic src_clear, wdog_clear;
	logic [13:0] src_target, wdog_target;

	// A write that arrives before the fuse load waits until the load is done
	assign do_write = aw_full_reg && w_full_reg && !bvalid_reg && loaded_reg;

	// ----------------------------------------------------------------
	// Start-up targets
	// ----------------------------------------------------------------
	always_comb begin
		wdog_target = clk_startup_pkg::ZERO_CNT;
		// Real-time part counted on the watchdog oscillator, whatever clocks the chip
		case (csut_reg)
			clk_startup_pkg::SUT_SHORT: begin
				// RC source with reset pin disabled must leave time to enter programming
				if (rst_dis_reg && (csel_reg == clk_startup_pkg::CSEL_RC_8M
					|| csel_reg == clk_startup_pkg::CSEL_RC_1M)) begin
					wdog_target = clk_startup_pkg::WD_4MS;
				end
			end
			clk_startup_pkg::SUT_FAST: wdog_target = clk_startup_pkg::WD_4MS;
			clk_startup_pkg::SUT_SLOW: wdog_target = clk_startup_pkg::WD_64MS;
			default: wdog_target = clk_startup_pkg::ZERO_CNT;
		endcase
		// Wake counts 6CK only; reset counts 14CK
		if (state_reg == clk_startup_pkg::S_WAKE) begin
			src_target = clk_startup_pkg::CK_POWERDOWN;
		end else begin
			src_target = clk_startup_pkg::CK_RESET;
		end
	end

	tick_counter u_src_cnt (
		.clk(I_CLK_SYS),
		.rst_n(rst_n),
		.clear(src_clear),
		.tick(I_SRC_TICK),
		.target(src_target),
		.done(src_done)
	);

	tick_counter u_wdog_cnt (
		.clk(I_CLK_SYS),
		.rst_n(rst_n),
		.clear(wdog_clear),
		.tick(I_WDOG_TICK),
		.target(wdog_target),
		.done(wdog_done)
	);

	// ----------------------------------------------------------------
	// Start-up sequence and configuration
	// ----------------------------------------------------------------
	always_comb begin
		csel_next = csel_reg;
		csut_next = csut_reg;
		range_next = range_reg;
		cal_next = cal_reg;
		div8_next = div8_reg;
		rst_dis_next = rst_dis_reg;
		loaded_next = 1'b1;
		wake_req_next = wake_req_reg || I_WAKE;
		state_next = state_reg;
		src_clear = 1'b1;
		wdog_clear = 1'b1;
		// Fuses are caught after reset release, never under the async reset
		if (!loaded_reg) begin
			csel_next = I_FUSE_CLOCK_SELECT;
			csut_next = I_FUSE_STARTUP_TIME;
			div8_next = I_FUSE_DIVIDE_BY_EIGHT;
			rst_dis_next = I_FUSE_RESET_PIN_DISABLE;
			range_next = (I_FUSE_CLOCK_SELECT == clk_startup_pkg::CSEL_RC_1M);
			cal_next = I_FACTORY_CAL;
		end
		case (state_reg)
			clk_startup_pkg::S_IDLE: begin
				if (loaded_reg) begin
					state_next = clk_startup_pkg::S_SRC;
				end
			end
			clk_startup_pkg::S_SRC: begin
				src_clear = 1'b0;
				if (src_done) begin
					state_next = clk_startup_pkg::S_WDOG;
				end
			end
			clk_startup_pkg::S_WDOG: begin
				wdog_clear = 1'b0;
				if (wdog_done) begin
					state_next = clk_startup_pkg::S_RUN;
				end
			end
			clk_startup_pkg::S_RUN: begin
				if (wake_req_reg) begin
					wake_req_next = I_WAKE;
					state_next = clk_startup_pkg::S_WAKE;
				end
			end
			clk_startup_pkg::S_WAKE: begin
				src_clear = 1'b0;
				if (src_done) begin
					state_next = clk_startup_pkg::S_RUN;
				end
			end
			default: state_next = clk_startup_pkg::S_IDLE;
		endcase
		// Software writes: a new source restarts start-up counting
		if (do_write && !aw_bad_reg) begin
			case (aw_addr_reg)
				clk_startup_pkg::ADDR_CLOCK_SELECT: begin
					if (wstrb_reg[0]) begin
						csel_next = wdata_reg[clk_startup_pkg::CSEL_LSB +: 4];
						csut_next = wdata_reg[clk_startup_pkg::CSUT_LSB +: 2];
						state_next = clk_startup_pkg::S_WAKE;
					end
				end
				clk_startup_pkg::ADDR_MCU_CONTROL: begin
					if (wstrb_reg[0]) begin
						range_next = wdata_reg[clk_startup_pkg::RANGE_BIT];
					end
				end
				clk_startup_pkg::ADDR_OSC_CAL: begin
					if (wstrb_reg[0]) begin
						cal_next = wdata_reg[7:0];
					end
				end
				clk_startup_pkg::ADDR_WAKE: begin
					if (wstrb_reg[0] && state_reg == clk_startup_pkg::S_RUN) begin
						state_next = clk_startup_pkg::S_WAKE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			csel_reg <= clk_startup_pkg::CSEL_DEFAULT;
			csut_reg <= clk_startup_pkg::SUT_DEFAULT;
			range_reg <= 1'b0;
			cal_reg <= 8'h00;
			div8_reg <= clk_startup_pkg::DIV8_DEFAULT;
			rst_dis_reg <= 1'b0;
			loaded_reg <= 1'b0;
			wake_req_reg <= 1'b0;
			state_reg <= clk_startup_pkg::S_IDLE;
		end else begin
			csel_reg <= csel_next;
			csut_reg <= csut_next;
			range_reg <= range_next;
			cal_reg <= cal_next;
			div8_reg <= div8_next;
			rst_dis_reg <= rst_dis_next;
			loaded_reg <= loaded_next;
			wake_req_reg <= wake_req_next;
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator controls
	// ----------------------------------------------------------------
	always_comb begin
		case (csel_reg)
			clk_startup_pkg::CSEL_WD_128K, clk_startup_pkg::CSEL_PLL_XOSC, clk_startup_pkg::CSEL_PLL_XCLK,
			clk_startup_pkg::CSEL_XOSC_C, clk_startup_pkg::CSEL_XOSC_D: O_RC_ENABLE = 1'b0;
			default: O_RC_ENABLE = 1'b1;
		endcase
	end

	assign O_RC_RANGE_1M = range_reg;
	assign O_RC_TRIM = cal_reg;
	assign O_WDOG_CLK_SELECT = (csel_reg == clk_startup_pkg::CSEL_WD_128K);
	assign O_DIVIDE_BY_EIGHT = div8_reg;

	clock_gate_glitchless u_gate (
		.clk(I_CLK_SYS),
		.rst_n(rst_n),
		.en_req(state_reg == clk_startup_pkg::S_RUN),
		.en_out(O_SYS_CLK_EN)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	always_comb begin
		status_word = 32'h0;
		status_word[clk_startup_pkg::ST_RC_EN] = O_RC_ENABLE;
		status_word[clk_startup_pkg::ST_RUN] = O_SYS_CLK_EN;
		status_word[clk_startup_pkg::ST_RANGE] = range_reg;
		status_word[clk_startup_pkg::ST_DIV8] = div8_reg;
		status_word[clk_startup_pkg::ST_RST_DIS] = rst_dis_reg;
		status_word[clk_startup_pkg::ST_STATE_LSB +: 3] = state_reg;
	end

	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		aw_addr_next = aw_addr_reg;
		aw_bad_next = aw_bad_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_next = 1'b1;
			aw_addr_next = s_axi_awaddr[7:0];
			// The master may move the address once it is taken, so the range check is kept here
			aw_bad_next = (s_axi_awaddr[31:8] != 24'h0);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (do_write) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = 2'h0;
			if (aw_bad_reg || !(aw_addr_reg == clk_startup_pkg::ADDR_CLOCK_SELECT
				|| aw_addr_reg == clk_startup_pkg::ADDR_MCU_CONTROL || aw_addr_reg == clk_startup_pkg::ADDR_OSC_CAL
				|| aw_addr_reg == clk_startup_pkg::ADDR_WAKE)) begin
				bresp_next = 2'h2;
			end
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next = 2'h0;
			rdata_next = 32'h0;
			case (s_axi_araddr[7:0])
				clk_startup_pkg::ADDR_CLOCK_SELECT: begin
					rdata_next[clk_startup_pkg::CSEL_LSB +: 4] = csel_reg;
					rdata_next[clk_startup_pkg::CSUT_LSB +: 2] = csut_reg;
				end
				clk_startup_pkg::ADDR_MCU_CONTROL: rdata_next[clk_startup_pkg::RANGE_BIT] = range_reg;
				clk_startup_pkg::ADDR_OSC_CAL: rdata_next[7:0] = cal_reg;
				clk_startup_pkg::ADDR_STATUS: rdata_next = status_word;
				clk_startup_pkg::ADDR_WAKE: rdata_next = 32'h0;
				default: rresp_next = 2'h2;
			endcase
			if (s_axi_araddr[31:8] != 24'h0) begin
				rresp_next = 2'h2;
				rdata_next = 32'h0;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			aw_bad_reg <= 1'b0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= 2'h0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			aw_addr_reg <= aw_addr_next;
			aw_bad_reg <= aw_bad_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready = !w_full_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
endmodule

//--- tb/clock_source_startup_select_sva.sv
// Checker for the clock source start-up block: bus answers, clock gate release, fixed copies.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module clock_source_startup_select_sva (
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic I_SRC_TICK,
	input wire logic I_WDOG_TICK,
	input wire logic I_WAKE,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic O_RC_ENABLE,
	input wire logic [7:0] O_RC_TRIM,
	input wire logic O_WDOG_CLK_SELECT,
	input wire logic O_SYS_CLK_EN,
	input wire logic O_DIVIDE_BY_EIGHT
);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	logic [2:0] since_tick_reg;
	logic [2:0] run_cnt_reg;
	// Both saturate, so a long quiet spell never wraps into a false recent tick
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			since_tick_reg <= 3'h7;
			run_cnt_reg <= 3'h0;
		end else begin
			since_tick_reg <= (I_SRC_TICK || I_WDOG_TICK) ? 3'h0 : since_tick_reg + {2'h0, since_tick_reg != 3'h7};
			run_cnt_reg <= run_cnt_reg + {2'h0, run_cnt_reg != 3'h7};
		end
	end
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RSTN);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_rc_off_wdog;
		O_WDOG_CLK_SELECT |-> !O_RC_ENABLE;
	endproperty
	a_rc_off_wdog: assert property (p_rc_off_wdog)
		else $error("RC on with 128 kHz source");
	property p_gate_after_reset;
		$rose(I_RSTN) |-> !O_SYS_CLK_EN [*4];
	endproperty
	a_gate_after_reset: assert property (p_gate_after_reset)
		else $error("clock released right after reset");
	property p_gate_needs_tick;
		$rose(O_SYS_CLK_EN) |-> since_tick_reg <= 3'h4;
	endproperty
	a_gate_needs_tick: assert property (p_gate_needs_tick)
		else $error("clock released with no recent tick");
	property p_gate_stands;
		O_SYS_CLK_EN && !I_WAKE && !$past(I_WAKE) && !$past(I_WAKE, 2) && !s_axi_awvalid
			&& !$past(s_axi_awvalid) && !s_axi_bvalid |=> O_SYS_CLK_EN;
	endproperty
	a_gate_stands: assert property (p_gate_stands)
		else $error("clock gated with no cause");
	property p_bvalid_holds;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bvalid_holds: assert property (p_bvalid_holds)
		else $error("write response dropped early");
	property p_rvalid_holds;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rvalid_holds: assert property (p_rvalid_holds)
		else $error("read data dropped early");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read not answered next cycle");
	property p_trim_by_write;
		run_cnt_reg == 3'h7 && $changed(O_RC_TRIM) |-> s_axi_bvalid;
	endproperty
	a_trim_by_write: assert property (p_trim_by_write)
		else $error("trim changed without a write");
	property p_div8_fixed;
		run_cnt_reg == 3'h7 |-> $stable(O_DIVIDE_BY_EIGHT);
	endproperty
	a_div8_fixed: assert property (p_div8_fixed)
		else $error("divide copy changed after load");
endmodule

bind clock_source_startup_select clock_source_startup_select_sva u_sva (
	.I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_SRC_TICK(I_SRC_TICK), .I_WDOG_TICK(I_WDOG_TICK),
	.I_WAKE(I_WAKE), .s_axi_awvalid(s_axi_awvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .O_RC_ENABLE(O_RC_ENABLE), .O_RC_TRIM(O_RC_TRIM),
	.O_WDOG_CLK_SELECT(O_WDOG_CLK_SELECT), .O_SYS_CLK_EN(O_SYS_CLK_EN), .O_DIVIDE_BY_EIGHT(O_DIVIDE_BY_EIGHT)
);

//--- tb/clock_source_startup_select_tb_top.sv
// Testbench for the clock source start-up block: fuse load, start-up counts, registers, wake.
// Assumes the design package is compiled first; the bench drives ticks and the bus itself.
`timescale 1ns/1ns
module clock_source_startup_select_tb_top;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic [3:0] f_csel = 4'h2;
	logic [1:0] f_csut = 2'h2;
	logic f_div8 = 1'h1;
	logic f_rdis = 1'h0;
	logic [7:0] f_cal = 8'h00;
	logic src_tick = 1'h0;
	logic wd_tick = 1'h0;
	logic wake = 1'h0;
	logic [31:0] awaddr = 32'h0;
	logic awvalid = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic [31:0] araddr = 32'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, rc_en, range_1m, wdog_sel, sys_en, div8_out;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [31:0] rdata;
	logic [7:0] trim;
	int fails = 0;
	int checks_done = 0;
	// Rows: select, startup code, reset pin fuse, watchdog ticks expected
	logic [3:0] t_csel [14] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h6, 4'h0, 4'h1, 4'h4, 4'h5, 4'hc, 4'hd};
	logic [1:0] t_csut [14] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
	logic t_rdis [14] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
	int t_wd [14] = '{8192, 0, 512, 512, 0, 512, 8192, 0, 0, 0, 0, 0, 0, 0};

	always #2 clk_sys = ~clk_sys;

	clock_source_startup_select uut (
		.I_CLK_SYS(clk_sys), .I_RSTN(rst_n), .I_FUSE_CLOCK_SELECT(f_csel), .I_FUSE_STARTUP_TIME(f_csut),
		.I_FUSE_DIVIDE_BY_EIGHT(f_div8), .I_FUSE_RESET_PIN_DISABLE(f_rdis), .I_FACTORY_CAL(f_cal),
		.I_SRC_TICK(src_tick), .I_WDOG_TICK(wd_tick), .I_WAKE(wake), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.O_RC_ENABLE(rc_en), .O_RC_RANGE_1M(range_1m), .O_RC_TRIM(trim), .O_WDOG_CLK_SELECT(wdog_sel),
		.O_SYS_CLK_EN(sys_en), .O_DIVIDE_BY_EIGHT(div8_out)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		repeat (50) begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid === 1'h1) begin
				r = bresp;
				bready <= 1'h0;
				return;
			end
		end
		fails++;
		give_verdict();
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= {24'h0, a};
		arvalid <= 1'h1;
		rready <= 1'h1;
		repeat (50) begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid === 1'h1) begin
				d = rdata;
				r = rresp;
				rready <= 1'h0;
				return;
			end
		end
		fails++;
		give_verdict();
	endtask
	// One-cycle pulses with a gap, as the oscillators are far slower than the system clock
	task automatic ticks(input logic wd, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			wd_tick <= wd;
			src_tick <= !wd;
			@(posedge clk_sys);
			wd_tick <= 1'h0;
			src_tick <= 1'h0;
		end
	endtask
	task automatic wait_en(input logic v);
		repeat (8) begin
			@(posedge clk_sys);
			if (sys_en === v) begin
				check(sys_en, v);
				return;
			end
		end
		fails++;
		give_verdict();
	endtask
	task automatic idle_off;
		repeat (4) @(posedge clk_sys);
		check(sys_en, 32'h0);
	endtask
	task automatic startup(input int n_src, input int n_wd);
		repeat (2) @(posedge clk_sys);
		ticks(1'h0, n_src - 1);
		idle_off();
		ticks(1'h0, 1);
		if (n_wd > 0) begin
			idle_off();
			ticks(1'h1, n_wd - 1);
			idle_off();
			ticks(1'h1, 1);
		end
		wait_en(1'h1);
	endtask
	task automatic do_reset(input int i);
		@(posedge clk_sys);
		rst_n <= 1'h0;
		f_csel <= t_csel[i];
		f_csut <= t_csut[i];
		f_rdis <= t_rdis[i];
		f_div8 <= !i[0];
		f_cal <= 8'h5a ^ i[7:0];
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (6) @(posedge clk_sys);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic [1:0] resp;
		logic exp_rc;
		for (int i = 0; i < 14; i++) begin
			do_reset(i);
			exp_rc = !(t_csel[i] inside {4'h3, 4'h4, 4'h5, 4'hc, 4'hd});
			check(rc_en, exp_rc);
			check(range_1m, t_csel[i] == 4'h6);
			check(wdog_sel, t_csel[i] == 4'h3);
			check(trim, 8'h5a ^ i[7:0]);
			check(div8_out, !i[0]);
			axi_read(clk_startup_pkg::ADDR_CLOCK_SELECT, rd, resp);
			check(rd, {26'h0, t_csut[i], t_csel[i]});
			startup(14, t_wd[i]);
			axi_read(clk_startup_pkg::ADDR_STATUS, rd, resp);
			check(rd, {21'h0, clk_startup_pkg::S_RUN, 3'h0, t_rdis[i], !i[0], t_csel[i] == 4'h6, 1'h1, exp_rc});
		end
		do_reset(1);
		startup(14, 0);
		axi_write(clk_startup_pkg::ADDR_OSC_CAL, 32'h3c, resp);
		check(trim, 8'h3c);
		check(resp, 2'h0);
		axi_read(clk_startup_pkg::ADDR_OSC_CAL, rd, resp);
		check(rd, 32'h3c);
		for (int v = 1; v >= 0; v--) begin
			axi_write(clk_startup_pkg::ADDR_MCU_CONTROL, v, resp);
			check(range_1m, v);
		end
		axi_write(8'h14, 32'h1, resp);
		check(resp, 2'h2);
		axi_read(8'h14, rd, resp);
		check(rd, 32'h0);
		check(resp, 2'h2);
		@(posedge clk_sys);
		wake <= 1'h1;
		@(posedge clk_sys);
		wake <= 1'h0;
		wait_en(1'h0);
		startup(6, 0);
		axi_write(clk_startup_pkg::ADDR_WAKE, 32'h1, resp);
		wait_en(1'h0);
		startup(6, 0);
		axi_write(clk_startup_pkg::ADDR_CLOCK_SELECT, 32'h03, resp);
		check(rc_en, 32'h0);
		check(wdog_sel, 32'h1);
		wait_en(1'h0);
		startup(6, 0);
		give_verdict();
	end
endmodule
